// ==== design/dscd_pkg.sv ====
/*
  dscd_pkg: constants, encodings and buffer states for the serial DAC command decoder.
  Assumes a 100 MHz system clock and a host-driven serial clock of any phase.
*/
package dscd_pkg;

  localparam int           DSCD_CHANNELS   = 8;
  localparam int           DSCD_CODE_W     = 12;
  localparam int           DSCD_WORD_W     = 16;
  localparam int           DSCD_CTRL_W     = 4;
  localparam int           DSCD_CNT_W      = 5;

  // bit positions within the serial frame
  localparam logic [4:0]   DSCD_CMD_LAST   = 5'h07;
  localparam logic [4:0]   DSCD_WORD_LAST  = 5'h17;
  localparam logic [4:0]   DSCD_CNT_SAT    = 5'h18;
  localparam logic [3:0]   DSCD_DAC_SELECT = 4'h1;

  // control field codes
  localparam logic [3:0]   DSCD_C_NOP      = 4'h0;
  localparam logic [3:0]   DSCD_C_RESET    = 4'h1;
  localparam logic [3:0]   DSCD_C_IN_FIRST = 4'h2;
  localparam logic [3:0]   DSCD_C_IN_LAST  = 4'h9;
  localparam logic [3:0]   DSCD_C_WR_LOW   = 4'ha;
  localparam logic [3:0]   DSCD_C_WR_HIGH  = 4'hb;
  localparam logic [3:0]   DSCD_C_WR_ALL   = 4'hc;
  localparam logic [3:0]   DSCD_C_IN_ALL   = 4'hd;
  localparam logic [3:0]   DSCD_C_XFER     = 4'he;
  localparam logic [3:0]   DSCD_C_POWER    = 4'hf;

  // data field positions
  localparam int           DSCD_SEL_LSB    = 4;
  localparam int           DSCD_PRESET_A   = 11;
  localparam int           DSCD_PRESET_B   = 9;
  localparam int           DSCD_PMODE_LSB  = 1;

  // power mode codes in data bits 3..1
  localparam logic [2:0]   DSCD_PM_UP      = 3'h1;
  localparam logic [2:0]   DSCD_PM_HIZ     = 3'h2;
  localparam logic [2:0]   DSCD_PM_1K      = 3'h4;
  localparam logic [2:0]   DSCD_PM_100K_G  = 3'h0;
  localparam logic [2:0]   DSCD_PM_100K_R  = 3'h7;

  typedef enum logic [2:0] {
    DSCD_BUF_ACTIVE   = 3'b000,
    DSCD_BUF_HIZ      = 3'b001,
    DSCD_BUF_PD_1K    = 3'b010,
    DSCD_BUF_PD_100KG = 3'b011,
    DSCD_BUF_PD_100KR = 3'b100
  } dscd_buf_t;

  localparam dscd_buf_t    DSCD_BUF_RESET  = DSCD_BUF_PD_100KG;
  localparam logic [11:0]  DSCD_CODE_RESET = 12'h000;
  localparam logic [11:0]  DSCD_CODE_ZERO  = 12'h000;
  localparam logic [11:0]  DSCD_CODE_ONES  = 12'hfff;
  localparam logic [3:0]   DSCD_RES_LEAD   = 4'h0;

  // result step: full scale over this many codes, or this many millidegrees
  localparam int           DSCD_LSB_DIV    = 4096;
  localparam int           DSCD_LSB_MDEGC  = 125;

endpackage

// ==== design/dscd_sync2.sv ====
/*
  dscd_sync2: two-flop synchroniser for levels and toggles.
  Assumes d is stable for at least two destination clock edges per change.
*/
`timescale 1ns/1ps
module dscd_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // dscd_sync2

// ==== design/dscd_channel.sv ====
/*
  dscd_channel: one channel's input code, output code and buffer state.
  Assumes strobes are decoded one cycle wide by the parent, on the system clock.
*/
`timescale 1ns/1ps
module dscd_channel
  import dscd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        pre,
  input  wire logic        ld_in,
  input  wire logic        ld_out,
  input  wire logic        xfer,
  input  wire logic        pwr_set,
  input  wire dscd_buf_t   pwr_state,
  input  wire logic [11:0] data,
  output logic      [11:0] in_code,
  output logic      [11:0] out_code,
  output dscd_buf_t        buf_state
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_code   <= DSCD_CODE_RESET;
      out_code  <= DSCD_CODE_RESET;
      buf_state <= DSCD_BUF_RESET;
    end else begin
      if (clr) begin
        in_code  <= DSCD_CODE_ZERO;
        out_code <= DSCD_CODE_ZERO;
      end else if (pre) begin
        in_code  <= DSCD_CODE_ONES;
        out_code <= DSCD_CODE_ONES;
      end else begin
        if (ld_in)
          in_code <= data;
        if (ld_out)
          out_code <= data;
        else if (xfer)
          out_code <= in_code;
      end
      if (pwr_set)
        buf_state <= pwr_state;
    end
  end
endmodule // dscd_channel

// ==== design/dscd_decoder.sv ====
/*
  dscd_decoder: serial command decoder for an eight-channel 12-bit DAC plus
  result word readback on the serial output.
  Assumes the host frames each transfer with chip select and clocks data on
  the serial clock, which may stop between frames; system logic on clk_sys.
*/
// What this block does
// - word: four control bits, twelve data bits
// - shift data in on falling serial clock
// - reset command clears all codes, keeps buffers
// - preset command sets all codes, keeps buffers
// - codes 2..9 load one input register
// - codes a, b write-through half banks
// - code c writes through all channels
// - code d loads all inputs only
// - code e copies selected inputs to outputs
// - power-up mode activates selected buffers
// - power-down modes park selected buffers
// - short frame discards the partial word
// - result: four zeros, twelve bits, MSB first
// - serial output changes on falling clock
// - binary unipolar, two's complement otherwise
// - one code step per count, unscaled
`timescale 1ns/1ps
module dscd_decoder
  import dscd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic [11:0] adc_code,
  input  wire logic        adc_is_bipolar,
  input  wire logic        adc_is_temp,
  input  wire logic        adc_strobe,
  output logic [95:0]      dac_code_out,
  output logic [23:0]      buf_state_out,
  output logic             cmd_done
);

  logic                    rst_n;
  logic [4:0]              bit_cnt_reg;
  logic [14:0]             shift_reg;
  logic                    dac_sel_reg;
  logic                    rd_sel_reg;
  logic [15:0]             word_reg;
  logic                    word_tgl_reg;
  logic [15:0]             out_shift_reg;
  logic [15:0]             res_link_reg;
  logic                    res_seen_reg;
  logic                    res_tgl_link;
  logic [15:0]             res_word_reg;
  logic                    res_tgl_reg;
  logic                    word_tgl_sys;
  logic                    word_seen_reg;
  logic [95:0]             in_code_all;
  logic [95:0]             out_code_all;
  logic [23:0]             buf_all;
  logic                    evt;

  wire  [15:0]             shift_next = {shift_reg, sdi};
  wire  [7:0]              cmd_next   = shift_next[7:0];

  // reset release, two flops
  dscd_sync2 #(.W(1)) u_rst_sync (
    .clk   (clk_sys),
    .rst_n (arst_n),
    .d     (1'b1),
    .q     (rst_n)
  );

  // link side: chip select high clears the frame, so a short word never counts
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 15'h0000;
      dac_sel_reg <= 1'b0;
      rd_sel_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next[14:0];
      if (bit_cnt_reg != DSCD_CNT_SAT)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == DSCD_CMD_LAST) begin
        dac_sel_reg <= (cmd_next[7:4] == DSCD_DAC_SELECT);
        rd_sel_reg  <= (cmd_next[7:4] != DSCD_DAC_SELECT);
      end
    end
  end

  // word holding register only moves on the sixteenth data bit
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg     <= 16'h0000;
      word_tgl_reg <= 1'b0;
    end else if (!cs_n && dac_sel_reg && bit_cnt_reg == DSCD_WORD_LAST) begin
      word_reg     <= shift_next;
      word_tgl_reg <= ~word_tgl_reg;
    end
  end

  // result word comes across as a toggle; the word itself is held still
  dscd_sync2 #(.W(1)) u_res_sync (
    .clk   (sclk),
    .rst_n (rst_n),
    .d     (res_tgl_reg),
    .q     (res_tgl_link)
  );

  // limitation: a result arriving inside a readback frame waits for the next one
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      res_seen_reg <= 1'b0;
      res_link_reg <= 16'h0000;
    end else if (res_tgl_link != res_seen_reg && (cs_n || !rd_sel_reg)) begin
      res_seen_reg <= res_tgl_link;
      res_link_reg <= res_word_reg;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo           <= 1'b0;
      sdo_oe        <= 1'b0;
      out_shift_reg <= 16'h0000;
    end else if (bit_cnt_reg == DSCD_CMD_LAST && cmd_next[7:4] != DSCD_DAC_SELECT) begin
      sdo           <= res_link_reg[15];
      sdo_oe        <= 1'b1;
      out_shift_reg <= {res_link_reg[14:0], 1'b0};
    end else if (rd_sel_reg) begin
      sdo           <= out_shift_reg[15];
      out_shift_reg <= {out_shift_reg[14:0], 1'b0};
    end
  end

  // system side: result formatting
  wire        res_signed = adc_is_bipolar | adc_is_temp;
  wire [11:0] res_fmt    = res_signed ? {~adc_code[11], adc_code[10:0]} : adc_code;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_word_reg <= 16'h0000;
      res_tgl_reg  <= 1'b0;
    end else if (adc_strobe) begin
      res_word_reg <= {DSCD_RES_LEAD, res_fmt};
      res_tgl_reg  <= ~res_tgl_reg;
    end
  end

  // system side: command event from the link
  dscd_sync2 #(.W(1)) u_word_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .d     (word_tgl_reg),
    .q     (word_tgl_sys)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_seen_reg <= 1'b0;
      cmd_done      <= 1'b0;
    end else begin
      word_seen_reg <= word_tgl_sys;
      cmd_done      <= evt;
    end
  end

  // word_reg is stable for many cycles after its toggle lands here
  assign evt            = word_tgl_sys ^ word_seen_reg;
  wire [3:0]  ctrl      = word_reg[15:12];
  wire [11:0] data      = word_reg[11:0];
  wire [2:0]  pmode     = data[DSCD_PMODE_LSB +: 3];
  wire [7:0]  chan_sel  = data[DSCD_SEL_LSB +: 8];
  wire        is_rst    = evt && ctrl == DSCD_C_RESET;
  wire        cmd_clr   = is_rst && !data[DSCD_PRESET_A] && !data[DSCD_PRESET_B];
  wire        cmd_pre   = is_rst && data[DSCD_PRESET_A] && data[DSCD_PRESET_B];
  wire        cmd_lo    = evt && ctrl == DSCD_C_WR_LOW;
  wire        cmd_hi    = evt && ctrl == DSCD_C_WR_HIGH;
  wire        cmd_all   = evt && ctrl == DSCD_C_WR_ALL;
  wire        cmd_inall = evt && ctrl == DSCD_C_IN_ALL;
  wire        cmd_xfer  = evt && ctrl == DSCD_C_XFER;
  wire        cmd_pwr   = evt && ctrl == DSCD_C_POWER;
  wire        pmode_ok  = pmode == DSCD_PM_UP || pmode == DSCD_PM_HIZ || pmode == DSCD_PM_1K ||
                          pmode == DSCD_PM_100K_G || pmode == DSCD_PM_100K_R;

  dscd_buf_t pwr_state;
  always_comb begin
    case (pmode)
      DSCD_PM_UP:     pwr_state = DSCD_BUF_ACTIVE;
      DSCD_PM_HIZ:    pwr_state = DSCD_BUF_HIZ;
      DSCD_PM_1K:     pwr_state = DSCD_BUF_PD_1K;
      DSCD_PM_100K_R: pwr_state = DSCD_BUF_PD_100KR;
      default:        pwr_state = DSCD_BUF_PD_100KG;
    endcase
  end

  // a nop word matches no strobe below, so nothing moves
  genvar gi;
  generate
    for (gi = 0; gi < DSCD_CHANNELS; gi++) begin : g_chan
      localparam logic [3:0] C_IN   = DSCD_C_IN_FIRST + 4'(gi);
      localparam bit         IS_LOW = (gi < DSCD_CHANNELS / 2);
      wire bank_wr = IS_LOW ? cmd_lo : cmd_hi;
      wire ld_out  = bank_wr | cmd_all;
      wire ld_in   = (evt && ctrl == C_IN) | ld_out | cmd_inall;
      dscd_buf_t st;

      dscd_channel u_chan (
        .clk       (clk_sys),
        .rst_n     (rst_n),
        .clr       (cmd_clr),
        .pre       (cmd_pre),
        .ld_in     (ld_in),
        .ld_out    (ld_out),
        .xfer      (cmd_xfer && chan_sel[gi]),
        .pwr_set   (cmd_pwr && pmode_ok && chan_sel[gi]),
        .pwr_state (pwr_state),
        .data      (data),
        .in_code   (in_code_all[gi*12 +: 12]),
        .out_code  (out_code_all[gi*12 +: 12]),
        .buf_state (st)
      );
      assign buf_all[gi*3 +: 3] = st;
    end
  endgenerate

  assign dac_code_out  = out_code_all;
  assign buf_state_out = buf_all;

  // checks
  sequence s_word_lands;
    evt && ctrl == DSCD_C_WR_ALL;
  endsequence

  property p_all_write;
    @(posedge clk_sys) disable iff (!rst_n)
      s_word_lands |=> dac_code_out == {8{$past(data)}} && in_code_all == {8{$past(data)}};
  endproperty

  a_nop_no_change: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt && ctrl == DSCD_C_NOP |=> $stable(dac_code_out) && $stable(in_code_all) && $stable(buf_state_out))
    else $error("nop word changed state");

  a_reset_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_clr |=> dac_code_out == 96'h0 && in_code_all == 96'h0 && $stable(buf_state_out))
    else $error("reset command did not clear codes");

  a_preset_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_pre |=> &dac_code_out && &in_code_all && $stable(buf_state_out))
    else $error("preset command did not set codes");

  a_single_input_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt && ctrl == DSCD_C_IN_FIRST |=> in_code_all[11:0] == $past(data) && $stable(dac_code_out))
    else $error("channel zero input load wrong");

  a_low_bank_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_lo |=> dac_code_out[47:0] == {4{$past(data)}} && $stable(dac_code_out[95:48]))
    else $error("low bank write-through wrong");

  a_all_write: assert property (p_all_write)
    else $error("write-through all wrong");

  a_input_all_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_inall |=> in_code_all == {8{$past(data)}} && $stable(dac_code_out))
    else $error("input-all load touched outputs");

  a_xfer_selected: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_xfer && chan_sel[7] && !chan_sel[0] |=>
      dac_code_out[95:84] == $past(in_code_all[95:84]) && $stable(dac_code_out[11:0]))
    else $error("transfer did not follow select bits");

  a_power_up_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_pwr && pmode == DSCD_PM_UP && chan_sel[0] |=> buf_state_out[2:0] == DSCD_BUF_ACTIVE)
    else $error("power-up did not activate buffer");

  a_power_down_hiz: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_pwr && pmode == DSCD_PM_HIZ && chan_sel[7] && !chan_sel[3] |=>
      buf_state_out[23:21] == DSCD_BUF_HIZ && $stable(buf_state_out[11:9]))
    else $error("high impedance power-down wrong");

  a_short_frame: assert property (@(negedge sclk) disable iff (!rst_n)
    bit_cnt_reg != DSCD_WORD_LAST |=> $stable(word_tgl_reg))
    else $error("word taken before sixteen data bits");

  a_result_format: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adc_strobe && adc_is_temp |=>
      res_word_reg == {4'h0, ~$past(adc_code[11]), $past(adc_code[10:0])})
    else $error("signed result format wrong");

  a_result_lead: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adc_strobe && !res_signed |=> res_word_reg == {4'h0, $past(adc_code)})
    else $error("unipolar result format wrong");

  a_sdo_shift: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
    rd_sel_reg ##1 rd_sel_reg && !cs_n |-> sdo == $past(out_shift_reg[15]))
    else $error("serial output not shifted on falling edge");

  a_high_bank_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_hi |=> dac_code_out[95:48] == {4{$past(data)}} && $stable(dac_code_out[47:0]))
    else $error("high bank write-through wrong");

  a_input_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt && ctrl >= DSCD_C_IN_FIRST && ctrl <= DSCD_C_IN_LAST |=> $stable(dac_code_out) && $stable(buf_state_out))
    else $error("input load touched outputs");

  a_xfer_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_xfer && chan_sel[0] && !chan_sel[7] |=>
      dac_code_out[11:0] == $past(in_code_all[11:0]) && $stable(dac_code_out[95:84]))
    else $error("transfer of channel zero wrong");

  // malformed words must leave every register alone
  a_mixed_preset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_rst && data[DSCD_PRESET_A] != data[DSCD_PRESET_B] |=> $stable(dac_code_out) && $stable(in_code_all))
    else $error("mixed reset word changed codes");

  a_bad_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_pwr && !pmode_ok |=> $stable(buf_state_out))
    else $error("reserved power code changed buffers");

  a_power_codes_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_pwr |=> $stable(dac_code_out) && $stable(in_code_all))
    else $error("power command changed codes");

  a_bipolar_format: assert property (@(posedge clk_sys) disable iff (!rst_n)
    adc_strobe && adc_is_bipolar |=> res_word_reg == {4'h0, ~$past(adc_code[11]), $past(adc_code[10:0])})
    else $error("bipolar result format wrong");

  // readback start: first result bit on the line right after the command byte
  sequence s_read_cmd;
    bit_cnt_reg == DSCD_CMD_LAST && cmd_next[7:4] != DSCD_DAC_SELECT;
  endsequence

  a_sdo_first_bit: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
    s_read_cmd |=> sdo_oe && sdo == $past(res_link_reg[15]))
    else $error("first result bit not driven after command byte");

  a_sdo_quiet: assert property (@(negedge sclk) disable iff (!rst_n)
    dac_sel_reg |-> !sdo_oe)
    else $error("serial output driven in a command frame");

endmodule // dscd_decoder

// ==== tb/dscd_host.sv ====
/*
  dscd_host: behavioural serial host that frames command byte and word.
  Assumes the bench calls frame() between frames only; link clock idles low.
*/
`timescale 1ns/1ps
module dscd_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // half is the half period in ns: 3 gives the nominal 6 ns link clock
  task automatic frame(input logic [7:0] cmd, input logic [15:0] word, input int nbits, input int half,
                       output logic [15:0] rd, output logic oe_ok);
    logic [23:0] all_bits;
    all_bits = {cmd, word};
    rd       = 16'h0000;
    oe_ok    = 1'b1;
    cs_n     = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      #(half);
      sclk = 1'b1;
      if (i >= 8) begin
        rd[23-i] = sdo;
        oe_ok    = oe_ok & sdo_oe;
      end
      // data moves on the rising edge, clear of the sampling edge
      sdi = all_bits[23-i];
      #(half);
      sclk = 1'b0;
    end
    #(half);
    cs_n = 1'b1;
    // released line: inverse of last bit so a stale value never looks valid
    sdi  = ~sdi;
  endtask
endmodule // dscd_host

// ==== tb/tb.sv ====
/*
  tb: self-checking bench for dscd_decoder against a channel model.
  Assumes dscd_host drives the serial link and the bench drives the result inputs.
*/
`timescale 1ns/1ps
module tb
  import dscd_pkg::*;
;
  logic        clk_sys, arst_n, sclk, cs_n, sdi, sdo, sdo_oe, cmd_done;
  logic [11:0] adc_code;
  logic        adc_is_bipolar, adc_is_temp, adc_strobe;
  logic [95:0] dac_code_out;
  logic [23:0] buf_state_out;
  logic [15:0] rd;
  logic        oe_ok;
  int          n_mismatch, tests_run;
  int          m_in[8], m_out[8], m_buf[8];

  dscd_decoder i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
                      .sdo_oe(sdo_oe), .adc_code(adc_code), .adc_is_bipolar(adc_is_bipolar),
                      .adc_is_temp(adc_is_temp), .adc_strobe(adc_strobe), .dac_code_out(dac_code_out),
                      .buf_state_out(buf_state_out), .cmd_done(cmd_done));
  dscd_host i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic int pm(logic [2:0] m);
    case (m)
      3'h1: return 0;
      3'h2: return 1;
      3'h4: return 2;
      3'h0: return 3;
      3'h7: return 4;
      default: return -1;
    endcase
  endfunction

  function automatic int legal(logic [15:0] w);
    if (w[15:12] == 4'h0) return 0;
    if (w[15:12] == 4'h1) return int'(w[11] == w[9]);
    if (w[15:12] == 4'hf) return int'(pm(w[3:1]) >= 0);
    return 1;
  endfunction

  task automatic model(logic [15:0] w);
    int c, d;
    c = w[15:12];
    d = w[11:0];
    for (int ch = 0; ch < 8; ch++) begin
      if (c == 1 && legal(w) == 1) begin
        m_in[ch]  = w[11] ? 'hfff : 0;
        m_out[ch] = m_in[ch];
      end
      if (c == ch + 2 || c == 12 || c == 13 || c == 10 + ch / 4) m_in[ch] = d;
      if (c == 12 || c == 10 + ch / 4) m_out[ch] = d;
      if (c == 14 && w[4+ch]) m_out[ch] = m_in[ch];
      if (c == 15 && w[4+ch] && legal(w) == 1) m_buf[ch] = pm(w[3:1]);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp_dac;
    for (int c = 0; c < 8; c++) begin
      tests_run++;
      if (dac_code_out[12*c+:12] !== 12'(m_out[c]) || buf_state_out[3*c+:3] !== 3'(m_buf[c])) begin
        n_mismatch++;
        $display("MISMATCH %0t channel %0d code %h state %b", $time, c, dac_code_out[12*c+:12],
                 buf_state_out[3*c+:3]);
      end
    end
  endtask

  task automatic cmp_word(logic [15:0] got, logic [15:0] exp, logic oe);
    tests_run++;
    if (got !== exp || oe !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t readback %h expected %h", $time, got, exp);
    end
  endtask

  // ignored or cut words get a fixed wait that covers the apply latency
  task automatic send(logic [15:0] w, int nbits, int half);
    int k;
    @(negedge clk_sys);
    #1.3;
    i_host.frame({DSCD_DAC_SELECT, w[3:0] ^ w[15:12]}, w, nbits, half, rd, oe_ok);
    if (nbits == 24) model(w);
    if (nbits == 24 && legal(w) == 1) begin
      for (k = 0; k < 300; k++) begin
        @(posedge clk_sys);
        #1;
        if (cmd_done === 1'b1) break;
      end
      if (k == 300) begin
        n_mismatch++;
        $display("MISMATCH %0t no completion", $time);
        end_sim();
      end
    end else repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp_dac();
  endtask

  initial begin
    arst_n         = 1'b0;
    adc_code       = 12'h000;
    adc_is_bipolar = 1'b0;
    adc_is_temp    = 1'b0;
    adc_strobe     = 1'b0;
    n_mismatch     = 0;
    tests_run      = 0;
    for (int c = 0; c < 8; c++) begin
      m_in[c]  = 0;
      m_out[c] = 0;
      m_buf[c] = 3;
    end
    void'($urandom(99031));
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    cmp_dac();
    $display("test reset done");
    for (int c = 2; c < 10; c++) send({4'(c), 12'($urandom)}, 24, 3);
    send({4'he, 8'($urandom), 4'h0}, 24, 3);
    for (int c = 10; c < 14; c++) begin
      send({4'(c), 12'($urandom)}, 24, 3);
      send({4'he, 8'($urandom), 4'h0}, 24, 3);
    end
    send(16'he9e0, 24, 3);
    send(16'he010, 24, 3);
    $display("test loads done");
    for (int m = 0; m < 8; m++) send({4'hf, 8'($urandom), 3'(m), 1'b1}, 24, 3);
    send(16'hf012, 24, 3);
    send(16'hf0f4, 24, 3);
    $display("test power done");
    send(16'h1aff, 24, 3);
    send(16'h1800, 24, 3);
    send(16'h15ff, 24, 3);
    send(16'h1400, 24, 3);
    send({4'h0, 12'($urandom)}, 24, 3);
    $display("test clear done");
    send({4'hc, 12'($urandom)}, 20, 3);
    send({4'hc, 12'($urandom)}, 8, 3);
    send({4'hc, 12'($urandom)}, 24, 3);
    $display("test abort done");
    for (int r = 0; r < 3; r++) begin
      logic [11:0] code;
      code = 12'($urandom);
      @(negedge clk_sys);
      adc_code       = code;
      adc_is_bipolar = (r == 1);
      adc_is_temp    = (r == 2);
      adc_strobe     = 1'b1;
      @(negedge clk_sys);
      adc_strobe = 1'b0;
      // a plain frame lets the link domain take up the new result
      send({4'h0, 12'($urandom)}, 24, 3);
      @(negedge clk_sys);
      #1.3;
      i_host.frame(8'h2c, 16'($urandom), 24, 3, rd, oe_ok);
      cmp_word(rd, {4'h0, (r == 0) ? code : code ^ 12'h800}, oe_ok);
    end
    $display("test readback done");
    end_sim();
  end
endmodule // tb
